// ==== common/sppc_defines.svh ====
`ifndef SPPC_DEFINES_SVH
`define SPPC_DEFINES_SVH

// Register byte offsets on the APB side
`define SPPC_OFF_INPUT 8'h00
`define SPPC_OFF_DIR 8'h04
`define SPPC_OFF_DRIVE 8'h08
`define SPPC_OFF_PULL 8'h0C
`define SPPC_OFF_POLARITY 8'h10
`define SPPC_OFF_FLAG 8'h14

// Port geometry and field positions
`define SPPC_NPINS 6
`define SPPC_PIN_NMI 1
`define SPPC_PIN_IRQ 5
`define SPPC_PIN_PWM0 0
`define SPPC_PIN_PWM1 1

// Reset values of the writable fields
`define SPPC_RST_DIR 6'h00
`define SPPC_RST_DRIVE 6'h00
`define SPPC_RST_PULL 6'h00
`define SPPC_RST_POLARITY 6'h00
`define SPPC_RST_FLAG 6'h00

// Enabled clock cycles after reset before edges are believed
`define SPPC_PRIME_CYCLES 2'h3

`endif

// ==== common/sppc_pkg.sv ====
package sppc_pkg;

   typedef struct packed {
      logic [5:0] meta;
      logic [5:0] stable;
   } sppc_sync_t;

   typedef struct packed {
      logic [5:0] dir;
      logic [5:0] drive;
      logic [5:0] pull;
      logic [5:0] polarity;
      logic [5:0] flag;
      logic [5:0] prev;
      logic [1:0] prime;
      logic nmi_lock;
      logic [5:0] pin_oe;
      logic [5:0] pin_reduced;
      logic [5:0] pin_pull_en;
      logic [5:0] pin_pull_down;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } sppc_state_t;

endpackage

// ==== rtl/sppc_sync.sv ====
`timescale 1ns/10ps
`default_nettype none

module sppc_sync
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Pin levels
   input wire logic [5:0] pin_async,
   output logic [5:0] pin_sync
);

   sppc_pkg::sppc_sync_t s_q;
   sppc_pkg::sppc_sync_t s_d;

   // Second stage alone reads the first; nothing else may look at meta
   always_comb
   begin
      s_d = s_q;
      if (ce)
      begin
         s_d.meta = pin_async;
         s_d.stable = s_q.meta;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign pin_sync = s_q.stable;

   a_sync_two_stage: assert property (
      @(posedge pclk) disable iff (!presetn)
      (presetn && ce ##1 ce) |=> pin_sync == $past(pin_async, 2))
   else $error("pin synchroniser is not two stages deep");

endmodule

`default_nettype wire

// ==== rtl/sppc_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sppc_defines.svh"

module sppc_top
(
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Function owners on the same clock
   input wire logic irq_func_en,
   input wire logic nmi_mask,
   input wire logic [1:0] pwm_ch_en,
   // Pads
   input wire logic [5:0] pin_level,
   output logic [5:0] pin_oe,
   output logic [5:0] pin_reduced,
   output logic [5:0] pin_pull_en,
   output logic [5:0] pin_pull_down,
   // Edge flags to the interrupt logic
   output logic [5:0] pin_edge_flag
);

   ////////////////////////////////////////////////////////////////////////////////

   function automatic logic reg_sel(input logic [7:0] addr, input logic [7:0] off);
      reg_sel = (addr == off);
   endfunction

   function automatic logic [5:0] active_edges(input logic [5:0] now, input logic [5:0] was,
                                               input logic [5:0] pol);
      // Polarity 1 means rising, 0 means falling
      active_edges = (pol & now & ~was) | (~pol & ~now & was);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////

   logic [5:0] pin_sync;

   sppc_sync u_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .pin_async(pin_level),
      .pin_sync(pin_sync)
   );

   sppc_pkg::sppc_state_t s_q;
   sppc_pkg::sppc_state_t s_d;

   logic setup;
   logic wr_acc;
   logic mapped;
   logic [5:0] oe_next;
   logic [5:0] edges;
   logic [31:0] rd_val;

   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite && s_q.pready && !s_q.pslverr;
   assign mapped = reg_sel(paddr, `SPPC_OFF_INPUT) || reg_sel(paddr, `SPPC_OFF_DIR)
                   || reg_sel(paddr, `SPPC_OFF_DRIVE) || reg_sel(paddr, `SPPC_OFF_PULL)
                   || reg_sel(paddr, `SPPC_OFF_POLARITY) || reg_sel(paddr, `SPPC_OFF_FLAG);
   assign edges = active_edges(pin_sync, s_q.prev, s_q.polarity);

   ////////////////////////////////////////////////////////////////////////////////
   // Direction with function overrides

   always_comb
   begin
      oe_next = s_q.dir;
      // Pulse-width channels own pins 1 and 0 when enabled
      if (pwm_ch_en[0])
         oe_next[`SPPC_PIN_PWM0] = 1'b1;
      if (pwm_ch_en[1])
         oe_next[`SPPC_PIN_PWM1] = 1'b1;
      // The nonmaskable request outranks the pulse-width channel on pin 1
      if (s_q.nmi_lock || !nmi_mask)
         oe_next[`SPPC_PIN_NMI] = 1'b0;
      if (irq_func_en)
         oe_next[`SPPC_PIN_IRQ] = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux

   always_comb
   begin
      rd_val = 32'h0000_0000;
      if (reg_sel(paddr, `SPPC_OFF_INPUT))
         rd_val[5:0] = pin_sync;
      else if (reg_sel(paddr, `SPPC_OFF_DIR))
         rd_val[5:0] = s_q.dir;
      else if (reg_sel(paddr, `SPPC_OFF_DRIVE))
         rd_val[5:0] = s_q.drive;
      else if (reg_sel(paddr, `SPPC_OFF_PULL))
         rd_val[5:0] = s_q.pull;
      else if (reg_sel(paddr, `SPPC_OFF_POLARITY))
         rd_val[5:0] = s_q.polarity;
      else if (reg_sel(paddr, `SPPC_OFF_FLAG))
         rd_val[5:0] = s_q.flag;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      s_d = s_q;
      if (ce)
      begin
         // Zero wait states: answer one enabled edge after select, so a low ce only stretches the wait
         // Limitation: ce must be high on the edge that completes a transfer, the frozen answer still shows
         s_d.pready = psel && !s_q.pready;
         s_d.pslverr = psel && !s_q.pready && !mapped;
         if (psel && !s_q.pready && !pwrite)
            s_d.prdata = rd_val;

         // The input register has no storage, so a write there falls through
         if (wr_acc && reg_sel(paddr, `SPPC_OFF_DIR))
            s_d.dir = pwdata[5:0];
         if (wr_acc && reg_sel(paddr, `SPPC_OFF_DRIVE))
            s_d.drive = pwdata[5:0];
         if (wr_acc && reg_sel(paddr, `SPPC_OFF_PULL))
            s_d.pull = pwdata[5:0];
         if (wr_acc && reg_sel(paddr, `SPPC_OFF_POLARITY))
            s_d.polarity = pwdata[5:0];

         // Edges are distrusted until the synchroniser holds real pin data
         s_d.prev = pin_sync;
         if (s_q.prime != `SPPC_PRIME_CYCLES)
            s_d.prime = s_q.prime + 2'h1;
         if (wr_acc && reg_sel(paddr, `SPPC_OFF_FLAG))
            s_d.flag = s_q.flag & ~pwdata[5:0];
         if (s_q.prime == `SPPC_PRIME_CYCLES)
            s_d.flag = s_d.flag | edges;

         // Once cleared, the mask never gives the pin back until reset
         if (!nmi_mask)
            s_d.nmi_lock = 1'b1;

         s_d.pin_oe = oe_next;
         // Drive strength follows ownership only through the direction
         s_d.pin_reduced = oe_next & s_q.drive;
         s_d.pin_pull_en = ~oe_next & s_q.pull;
         s_d.pin_pull_down = s_q.polarity;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
         s_q.dir <= `SPPC_RST_DIR;
         s_q.drive <= `SPPC_RST_DRIVE;
         s_q.pull <= `SPPC_RST_PULL;
         s_q.polarity <= `SPPC_RST_POLARITY;
         s_q.flag <= `SPPC_RST_FLAG;
      end
      else
         s_q <= s_d;
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign pin_oe = s_q.pin_oe;
   assign pin_reduced = s_q.pin_reduced;
   assign pin_pull_en = s_q.pin_pull_en;
   assign pin_pull_down = s_q.pin_pull_down;
   assign pin_edge_flag = s_q.flag;

   ////////////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_input_read: assert property (
      (ce && setup && !pwrite && paddr == `SPPC_OFF_INPUT)
      |=> prdata == {26'h0000000, $past(pin_sync)})
   else $error("input register read does not show the pin level");

   a_input_nowrite: assert property (
      (ce && wr_acc && paddr == `SPPC_OFF_INPUT)
      |=> $stable(s_q.dir) && $stable(s_q.drive) && $stable(s_q.pull) && $stable(s_q.polarity))
   else $error("write to input register changed state");

   a_dir_plain: assert property (
      (ce && !irq_func_en && !s_q.nmi_lock && nmi_mask && pwm_ch_en == 2'h0)
      |=> pin_oe == $past(s_q.dir))
   else $error("pin direction does not follow the direction bits");

   a_irq_input: assert property (
      (ce && irq_func_en)
      |=> !pin_oe[`SPPC_PIN_IRQ]
          && (s_q.dir == $past(s_q.dir) || $past(wr_acc && paddr == `SPPC_OFF_DIR)))
   else $error("interrupt-request pin not forced to input");

   a_nmi_latch: assert property (
      (ce && !nmi_mask) |=> s_q.nmi_lock ##1 (s_q.nmi_lock && (!ce || !pin_oe[`SPPC_PIN_NMI])))
   else $error("nonmaskable pin not latched as input");

   a_pwm_output: assert property (
      (ce && pwm_ch_en[0]) |=> pin_oe[`SPPC_PIN_PWM0])
   else $error("pulse-width channel did not force its pin to output");

   a_drive_gate: assert property (
      (pin_reduced & ~pin_oe) == 6'h00)
   else $error("reduced drive shown on an input pin");

   a_pull_gate: assert property (
      (ce && !irq_func_en) |=> (pin_pull_en & pin_oe) == 6'h00
                               && pin_pull_en == ($past(s_q.pull) & ~pin_oe))
   else $error("pull device state wrong for pin direction");

   a_edge_sets: assert property (
      (ce && s_q.prime == `SPPC_PRIME_CYCLES && edges != 6'h00)
      |=> (pin_edge_flag & $past(edges)) == $past(edges))
   else $error("active edge did not set its flag");

   a_flag_clear: assert property (
      (ce && wr_acc && paddr == `SPPC_OFF_FLAG && edges == 6'h00)
      |=> (pin_edge_flag & $past(pwdata[5:0])) == 6'h00)
   else $error("write of one did not clear the flag");

endmodule

`default_nettype wire

// ==== testbench/sppc_pad_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module sppc_pad_model
(
   // Clock
   input wire logic pclk,
   // Pad controls from the port
   input wire logic [5:0] pin_oe,
   input wire logic [5:0] pin_pull_en,
   input wire logic [5:0] pin_pull_down,
   // Bench side: value the port drives, and an outside driver that wins
   input wire logic [5:0] out_val,
   input wire logic [5:0] ext_en,
   input wire logic [5:0] ext_val,
   // Pad levels back to the port
   output logic [5:0] pin_level
);
   logic [5:0] float_q = 6'h15;

   ////////////////////////////////////////////////////////////////
   // A floating pad wanders every cycle so no level is right by luck
   always_ff @(posedge pclk)
      float_q <= ~float_q;

   always_comb
   begin
      for (int i = 0; i < 6; i++)
      begin
         // An outside driver also stands for a short on an output
         if (ext_en[i])
            pin_level[i] = ext_val[i];
         else if (pin_oe[i])
            pin_level[i] = out_val[i];
         else if (pin_pull_en[i])
            pin_level[i] = ~pin_pull_down[i];
         else
            pin_level[i] = float_q[i];
      end
   end
endmodule

`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sppc_defines.svh"

module testbench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic irq_func_en = 1'b0;
   logic nmi_mask = 1'b1;
   logic [1:0] pwm_ch_en = 2'h0;
   logic [5:0] out_val = 6'h00;
   logic [5:0] ext_en = 6'h3F;
   logic [5:0] ext_val = 6'h00;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [5:0] pin_level;
   logic [5:0] pin_oe;
   logic [5:0] pin_reduced;
   logic [5:0] pin_pull_en;
   logic [5:0] pin_pull_down;
   logic [5:0] pin_edge_flag;
   logic [31:0] r;
   logic e;
   int mismatches = 0;
   int compares = 0;

   always #2 pclk = ~pclk;

   sppc_top u_sppc_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq_func_en(irq_func_en), .nmi_mask(nmi_mask), .pwm_ch_en(pwm_ch_en), .pin_level(pin_level),
      .pin_oe(pin_oe), .pin_reduced(pin_reduced), .pin_pull_en(pin_pull_en),
      .pin_pull_down(pin_pull_down), .pin_edge_flag(pin_edge_flag));

   sppc_pad_model u_sppc_pad_model (.pclk(pclk), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en),
      .pin_pull_down(pin_pull_down), .out_val(out_val), .ext_en(ext_en), .ext_val(ext_val),
      .pin_level(pin_level));

   ////////////////////////////////////////////////////////////////
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         $display("FAIL %s expected %h seen %h", what, exp, seen);
         mismatches++;
      end
   endtask

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd_v, output logic er);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Values read right after the edge are those sampled at it
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1);
      chk("access cycles", 32'(n), 32'h1);
      rd_v = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, r, e);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, r, e);
      chk("read data", r, exp);
   endtask

   // Outputs are registered, so give causes a few cycles to land
   task pchk(input int s, input logic [5:0] exp);
      logic [5:0] v;
      repeat (6) @(posedge pclk);
      case (s)
         0: v = pin_oe;
         1: v = pin_reduced;
         2: v = pin_pull_en;
         3: v = pin_pull_down;
         default: v = pin_edge_flag;
      endcase
      chk("pin output", {26'h0, v}, {26'h0, exp});
   endtask

   task test_done;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      test_done;
   end

   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 1; i < 6; i++)
         rd(8'(4 * i), 32'h0);
      apb(1'b0, 8'h18, 32'h0, r, e);
      chk("unmapped error", {31'h0, e}, 32'h1);
      ext_val <= 6'h2A;
      repeat (4) @(posedge pclk);
      rd(`SPPC_OFF_INPUT, 32'h2A);
      wr(`SPPC_OFF_INPUT, 32'h15);
      rd(`SPPC_OFF_INPUT, 32'h2A);
      wr(`SPPC_OFF_DIR, 32'h1C);
      pchk(0, 6'h1C);
      irq_func_en <= 1'b1;
      wr(`SPPC_OFF_DIR, 32'h3F);
      pchk(0, 6'h1F);
      rd(`SPPC_OFF_DIR, 32'h3F);
      wr(`SPPC_OFF_DRIVE, 32'h3F);
      pchk(1, 6'h1F);
      wr(`SPPC_OFF_DIR, 32'h0);
      pchk(1, 6'h00);
      pwm_ch_en <= 2'h3;
      pchk(0, 6'h03);
      pchk(1, 6'h03);
      rd(`SPPC_OFF_DIR, 32'h0);
      wr(`SPPC_OFF_PULL, 32'h3F);
      pchk(2, 6'h3C);
      pwm_ch_en <= 2'h0;
      irq_func_en <= 1'b0;
      wr(`SPPC_OFF_DIR, 32'h3F);
      pchk(2, 6'h00);
      wr(`SPPC_OFF_POLARITY, 32'h15);
      pchk(3, 6'h15);
      ext_en <= 6'h00;
      out_val <= 6'h33;
      repeat (4) @(posedge pclk);
      rd(`SPPC_OFF_INPUT, 32'h33);
      ext_en <= 6'h01;
      repeat (4) @(posedge pclk);
      rd(`SPPC_OFF_INPUT, 32'h32);
      ext_en <= 6'h3F;
      ext_val <= 6'h00;
      wr(`SPPC_OFF_POLARITY, 32'h01);
      wr(`SPPC_OFF_FLAG, 32'h3F);
      pchk(4, 6'h00);
      ext_val <= 6'h03;
      pchk(4, 6'h01);
      ext_val <= 6'h00;
      pchk(4, 6'h03);
      wr(`SPPC_OFF_FLAG, 32'h01);
      rd(`SPPC_OFF_FLAG, 32'h02);
      // With the enable low the synchroniser and the flags must hold still
      ce <= 1'b0;
      ext_val <= 6'h01;
      pchk(4, 6'h02);
      ce <= 1'b1;
      pchk(4, 6'h03);
      nmi_mask <= 1'b0;
      pwm_ch_en <= 2'h2;
      pchk(0, 6'h3D);
      nmi_mask <= 1'b1;
      pchk(0, 6'h3D);
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(`SPPC_OFF_DIR, 32'h0);
      pchk(0, 6'h02);
      test_done;
   end
endmodule

`default_nettype wire
